/* File: logic/srl_latch_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - Top control bit one enables the latch; zero disables it.
// - Divider emits one-cycle pulse every 4<<code cycles, 4 to 512.
// - True output pin driven when latch enabled and true enable set.
// - Inverted output pin driven when latch enabled and inverted enable set.
// - Writing one to soft set bit pulses set input one cycle.
// - Writing one to soft reset bit pulses reset input one cycle.
// - Soft set and reset bits always read back zero.
// - All register bits reset to zero on any reset.
// - Set and reset high together leave the latch reset.
// - Enabled comparator output high sets or resets the latch, per its set and reset enables; disabled has no effect.
// - Enabled external pin high sets or resets the latch, per its set and reset enables.
// - Enabled divided-clock pulse drives reset or set input.
module srl_latch_ctrl (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [0:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cmp1_out,
  input  wire logic       i_cmp2_out,
  input  wire logic       i_external_latch_input_pin,
  output logic            o_true_output_pin,
  output logic            o_true_output_pin_oe,
  output logic            o_inverted_output_pin,
  output logic            o_inverted_output_pin_oe,
  output logic            o_divclk_pulse
);

  srl_pkg::srl_ctrl_s         ctrl_q;
  srl_pkg::srl_ctrl_s         ctrl_d;
  srl_pkg::srl_src_s          src_q;
  srl_pkg::srl_src_s          src_d;

  logic [srl_pkg::DIV_W-1:0]  div_cnt_q;
  logic [srl_pkg::DIV_W-1:0]  div_cnt_d;
  logic                       divclk_q;
  logic                       divclk_d;

  logic                       latch_q;
  logic                       latch_d;
  logic [7:0]                 rdata_q;
  logic [7:0]                 rdata_d;

  wire logic                      addr_ctrl;
  wire logic                      addr_src;
  wire logic                      wr_ctrl;
  wire logic                      wr_src;
  wire logic                      enabled;
  wire logic [2:0]                div_code;
  wire logic                      true_oe;
  wire logic                      inv_oe;
  wire logic                      soft_set;
  wire logic                      soft_rst;

  wire logic [srl_pkg::DIV_W-1:0] div_term;
  wire logic                      div_wrap;
  wire logic [srl_pkg::DIV_W-1:0] div_inc;

  wire srl_pkg::srl_srcs_s        lvl;
  wire srl_pkg::srl_srcs_s        set_en;
  wire srl_pkg::srl_srcs_s        rst_en;
  wire logic                      set_src;
  wire logic                      rst_src;
  wire logic                      set_in;
  wire logic                      rst_in;

  wire logic [7:0]                ctrl_rd;
  wire logic [7:0]                src_rd;
  wire logic [7:0]                rd_mux;

  wire logic                      pin_true;
  wire logic                      pin_inv;
  wire logic                      oe_true;
  wire logic                      oe_inv;

  // True when any source has both its enable bit and its level high
  function automatic logic any_enabled(input srl_pkg::srl_srcs_s lvl,
                                       input srl_pkg::srl_srcs_s en);
    any_enabled = |(lvl & en);
  endfunction

  // Last count of a period, N - 1 with N = 4 << code; one bit wider as N = 512 overflows
  function automatic logic [srl_pkg::DIV_W-1:0] div_last(input logic [2:0] code);
    logic [srl_pkg::DIV_W:0] period;
    period   = {1'b0, srl_pkg::DIV_BASE} << code;
    period   = period - {1'b0, srl_pkg::DIV_ONE};
    div_last = period[srl_pkg::DIV_W-1:0];
  endfunction

  // Register decode
  assign addr_ctrl = (i_addr == srl_pkg::ADDR_CTRL);
  assign addr_src  = (i_addr == srl_pkg::ADDR_SRC);
  assign wr_ctrl   = i_wr && addr_ctrl;
  assign wr_src    = i_wr && addr_src;

  assign enabled   = ctrl_q.latch_enable_bit;
  assign div_code  = ctrl_q.pulse_divider_select;
  assign true_oe   = ctrl_q.true_output_enable;
  assign inv_oe    = ctrl_q.inverted_output_enable;
  assign soft_set  = ctrl_q.soft_set_pulse;
  assign soft_rst  = ctrl_q.soft_reset_pulse;

  // Pulse bits self-clear the cycle after they are written; a write in that cycle wins
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d.soft_set_pulse   = 1'b0;
    ctrl_d.soft_reset_pulse = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = srl_pkg::srl_ctrl_s'(i_wdata);
    end
  end

  assign src_d = wr_src ? srl_pkg::srl_src_s'(i_wdata) : src_q;

  // Free-running divider; a code lowered mid-count wraps at once
  assign div_term  = div_last(div_code);
  assign div_wrap  = (div_cnt_q >= div_term);
  assign div_inc   = div_cnt_q + srl_pkg::DIV_ONE;

  assign div_cnt_d = div_wrap ? srl_pkg::DIV_ZERO : div_inc;
  assign divclk_d  = div_wrap;

  // Levels and per-side enables in pin, divided clock, comparator 2, comparator 1 order
  assign lvl    = '{pin: i_external_latch_input_pin,
                    divclk: divclk_q,
                    cmp2: i_cmp2_out,
                    cmp1: i_cmp1_out};
  assign set_en = '{pin: src_q.pin_set_enable,
                    divclk: src_q.divclk_set_enable,
                    cmp2: src_q.cmp2_set_enable,
                    cmp1: src_q.cmp1_set_enable};
  assign rst_en = '{pin: src_q.pin_reset_enable,
                    divclk: src_q.divclk_reset_enable,
                    cmp2: src_q.cmp2_reset_enable,
                    cmp1: src_q.cmp1_reset_enable};

  assign set_src = any_enabled(lvl, set_en);
  assign rst_src = any_enabled(lvl, rst_en);
  assign set_in  = soft_set | set_src;
  assign rst_in  = soft_rst | rst_src;

  // Reset wins when both inputs are high
  assign latch_d = rst_in ? 1'b0 : (set_in ? 1'b1 : latch_q);

  assign ctrl_rd = 8'(ctrl_q) & srl_pkg::CTRL_READ_MASK;
  assign src_rd  = 8'(src_q);
  assign rd_mux  = addr_ctrl ? ctrl_rd : src_rd;

  assign rdata_d = i_rd ? rd_mux : srl_pkg::READ_IDLE;

  // Pins show the latch only while it is enabled
  assign pin_true = enabled & latch_q;
  assign pin_inv  = enabled & ~latch_q;
  assign oe_true  = enabled & true_oe;
  assign oe_inv   = enabled & inv_oe;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= srl_pkg::srl_ctrl_s'(srl_pkg::CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      src_q <= srl_pkg::srl_src_s'(srl_pkg::SRC_RESET);
    end else begin
      src_q <= src_d;
    end
  end

  // Divider runs from reset whatever the enable bit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt_q <= srl_pkg::DIV_ZERO;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      divclk_q <= 1'b0;
    end else begin
      divclk_q <= divclk_d;
    end
  end

  // The latch holds no defined value after reset; it is cleared here for a clean start
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Read data stand one cycle, then return to idle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= srl_pkg::READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata                  = rdata_q;
  assign o_divclk_pulse           = divclk_q;
  assign o_true_output_pin        = pin_true;
  assign o_true_output_pin_oe     = oe_true;
  assign o_inverted_output_pin    = pin_inv;
  assign o_inverted_output_pin_oe = oe_inv;

endmodule // srl_latch_ctrl

/* File: logic/srl_pkg.sv */
package srl_pkg;

  // Register indices on the plain register port
  localparam logic [0:0] ADDR_CTRL = 1'h0;
  localparam logic [0:0] ADDR_SRC  = 1'h1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE  = 8'h00;

  // Control register field positions
  localparam int BIT_LATCH_EN   = 7;
  localparam int DIV_SEL_HI     = 6;
  localparam int DIV_SEL_LO     = 4;
  localparam int BIT_TRUE_OE    = 3;
  localparam int BIT_INV_OE     = 2;
  localparam int BIT_SOFT_SET   = 1;
  localparam int BIT_SOFT_RESET = 0;

  // Mask of bits that read back from the control register
  localparam logic [7:0] CTRL_READ_MASK = 8'hFC;

  // Divider: N = 4 << code, so the counter spans 9 bits for N = 512
  localparam int          DIV_W    = 9;
  localparam logic [DIV_W-1:0] DIV_BASE = 9'h004;
  localparam logic [DIV_W-1:0] DIV_ONE  = 9'h001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 9'h000;

  typedef struct packed {
    logic       latch_enable_bit;
    logic [2:0] pulse_divider_select;
    logic       true_output_enable;
    logic       inverted_output_enable;
    logic       soft_set_pulse;
    logic       soft_reset_pulse;
  } srl_ctrl_s;

  typedef struct packed {
    logic pin_set_enable;
    logic divclk_set_enable;
    logic cmp2_set_enable;
    logic cmp1_set_enable;
    logic pin_reset_enable;
    logic divclk_reset_enable;
    logic cmp2_reset_enable;
    logic cmp1_reset_enable;
  } srl_src_s;

  // Per-side source levels: pin, divided clock, comparator 2, comparator 1
  typedef struct packed {
    logic pin;
    logic divclk;
    logic cmp2;
    logic cmp1;
  } srl_srcs_s;

endpackage

/* File: tb/srl_chk_asserts.sv */
`timescale 1ns/1ps
module srl_chk (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic [0:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_true_output_pin,
  input wire logic       o_true_output_pin_oe,
  input wire logic       o_inverted_output_pin,
  input wire logic       o_inverted_output_pin_oe,
  input wire logic       o_divclk_pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire w0 = i_wr && !i_addr[0];
  wire r0 = i_rd && !i_addr[0];
  AST_TOE: assert property (w0 |=> o_true_output_pin_oe == &($past(i_wdata) | 8'h77))
    else $error("true oe");
  AST_IOE: assert property (w0 |=> o_inverted_output_pin_oe == &($past(i_wdata) | 8'h7B))
    else $error("inverted oe");
  AST_OFF: assert property (w0 && !i_wdata[7] |=> !(o_true_output_pin | o_inverted_output_pin))
    else $error("pins while off");
  AST_CPL: assert property (o_true_output_pin_oe && o_inverted_output_pin_oe |-> o_true_output_pin ^ o_inverted_output_pin)
    else $error("not complement");
  AST_RDB: assert property (w0 ##1 !i_wr ##1 r0 |=> o_rdata == ($past(i_wdata, 3) & 8'hFC))
    else $error("ctrl readback");
  AST_SOFT: assert property (r0 |=> o_rdata[1:0] == 2'h0)
    else $error("soft bits read");
  AST_DIV: assert property (o_divclk_pulse |=> !o_divclk_pulse [*3])
    else $error("pulse spacing");
  AST_RST: assert property (w0 && i_wdata[0] |-> ##2 !o_true_output_pin)
    else $error("soft reset");
endmodule // srl_chk
bind srl_latch_ctrl srl_chk srl_chk_i (.*);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        c1 = 1'b0, c2 = 1'b0, pin = 1'b0, tq, toe, nq, noe, dp;
  logic [0:0]  i_addr = 1'h0;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  int          miscompares = 0, num_checks = 0, n;
  // Pre-set nibble, source enables, cmp1 cmp2 pin levels, expected latch state
  logic [15:0] rows [11] = '{16'h0109, 16'h0205, 16'h0104, 16'h0803, 16'h018A, 16'h0401,
                            16'h1040, 16'h1024, 16'h1018, 16'h1082, 16'h100F};
  srl_latch_ctrl srl_latch_ctrl_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp1_out(c1), .i_cmp2_out(c2),
    .i_external_latch_input_pin(pin), .o_true_output_pin(tq), .o_true_output_pin_oe(toe),
    .o_inverted_output_pin(nq), .o_inverted_output_pin_oe(noe), .o_divclk_pulse(dp));
  always #12.5 i_clk = ~i_clk;
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge i_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic a, input logic [7:0] e);
    @(posedge i_clk) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("rdata", {8'h00, o_rdata}, {8'h00, e});
  endtask
  // Counts cycles up to the next divider pulse, bounded
  task automatic pw;
    n = 0;
    do begin @(posedge i_clk); #1 n++; end while (dp !== 1'b1 && n < 600);
    if (n >= 600) begin miscompares++; end_sim; end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (rows[k]) begin
      @(posedge i_clk) {c1, c2, pin} <= 3'h0;
      wr(1'h1, 8'h00);
      wr(1'h0, 8'h8D);
      if (rows[k][12]) wr(1'h0, 8'h8E);
      wr(1'h1, rows[k][11:4]);
      {c1, c2, pin} <= rows[k][3:1];
      repeat (12) @(posedge i_clk);
      #1 chk("q", {15'h0000, tq}, {15'h0000, rows[k][0]});
      chk("nq", {15'h0000, nq}, {15'h0000, ~rows[k][0]});
    end
    @(posedge i_clk) {c1, c2, pin} <= 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(1'h0, {1'b1, c[2:0], 4'h0});
      pw;
      pw;
      chk("period", n[15:0], 16'h0004 << c);
    end
    wr(1'h0, 8'hFF);
    rd(1'h0, 8'hFC);
    wr(1'h1, 8'h5A);
    rd(1'h1, 8'h5A);
    wr(1'h0, 8'h7C);
    #1 chk("oe", {14'h0000, toe, noe}, 16'h0000);
    wr(1'h0, 8'hFC);
    @(posedge i_clk) i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1 chk("pins", {11'h000, tq, toe, nq, noe, dp}, 16'h0000);
    rd(1'h0, 8'h00);
    rd(1'h1, 8'h00);
    end_sim;
  end
endmodule // tb
